// [rtl/nvirq_unit.sv]
// Enable, pending, active and priority state of the vectored interrupt unit.
`include "nvirq_params.svh"
`timescale 1ns/100ps
`default_nettype none
// Operation
// - Write-one set/clear enable, read enable state.
// - Disabled request still marks interrupt pending.
// - Active stays until reset or return.
// - Disabled interrupt never starts new activation.
// - Write-one set/clear pending, read pending state.
// - Clear-pending leaves active interrupt untouched.
// - Four 8-bit priority fields per word.
// - All registers in one address block.
// - 32 inputs, four priority levels each.
// - Separate non-maskable interrupt input.
// - Each input level or pulse sensitive.
module nvirq_unit
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Interrupt request pins
  input  wire logic [31:0] irqLine,
  input  wire logic        nmiLine,
  // Core side
  input  wire logic        coreAck,
  input  wire logic        excReturn,
  output logic             irqValid,
  output logic      [4:0]  irqNum,
  output logic             nmiReq
);
  localparam int N = `NVIRQ_NUM_IRQ;

  nvirq_pkg::nvirq_bus_t bus;
  nvirq_pkg::nvirq_word_t enable, pending, active, pulseMode;
  logic [31:0] sync1, sync2, sync3, lineLevel, linePrev;
  logic        nmiS1, nmiS2, nmiS3, nmiLevel;
  logic [255:0] allPrio;
  logic [31:0] reqEvent, next_pending, next_active;
  logic        sel, selNone;
  logic [4:0]  selNum;
  logic        actAny;
  logic [4:0]  actNum;

  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // Four levels per input
  // Only the two top bits of each byte are kept, giving four levels.
  function automatic logic [1:0] prioOf(input logic [255:0] p,
                                        input int k);
    prioOf = p[k*8 + `NVIRQ_PRIO_LSB +: 2];
  endfunction

  function automatic logic isPrio(input logic [7:0] a);
    isPrio = (a >= `NVIRQ_PRIO_OFF) && (a <= `NVIRQ_PRIO_LAST)
             && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [31:0] maskPrio(input logic [31:0] w);
    maskPrio = w & 32'hc0c0_c0c0;
  endfunction

  nvirq_prio_mem uPrio
  (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wrEn     (bus.wr && isPrio(bus.addr)),
    .wrIdx    (bus.addr[4:2]),
    .wrData   (maskPrio(bus.wdata)),
    .rdIdx    (bus.addr[4:2]),
    .rdData   (),
    .allPrio  (allPrio)
  );

  // Three-stage input synchroniser; a change counts when stages agree.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      lineLevel <= '0;
      linePrev <= '0;
      nmiS1 <= 1'b0;
      nmiS2 <= 1'b0;
      nmiS3 <= 1'b0;
      nmiLevel <= 1'b0;
    end
    else
    begin
      sync1 <= irqLine;
      sync2 <= sync1;
      sync3 <= sync2;
      for (int i = 0; i < N; i++)
        if (sync2[i] == sync3[i])
          lineLevel[i] <= sync3[i];
      linePrev <= lineLevel;
      nmiS1 <= nmiLine;
      nmiS2 <= nmiS1;
      nmiS3 <= nmiS2;
      if (nmiS2 == nmiS3)
        nmiLevel <= nmiS3;
    end
  end

  // Pulse mode catches a rising edge, level mode follows the line.
  assign reqEvent = (pulseMode & lineLevel & ~linePrev)
                  | (~pulseMode & lineLevel);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      enable <= '0;
    else if (bus.wr && bus.addr == `NVIRQ_SET_EN_OFF)
      enable <= enable | bus.wdata;
    else if (bus.wr && bus.addr == `NVIRQ_CLR_EN_OFF)
      enable <= enable & ~bus.wdata;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pulseMode <= '0;
    else if (bus.wr && bus.addr == `NVIRQ_SENSE_OFF)
      pulseMode <= bus.wdata;
  end

  // Lowest priority value, ties to the lower number
  always_comb
  begin
    selNone = 1'b1;
    selNum = '0;
    for (int i = N - 1; i >= 0; i--)
      if (pending[i] && enable[i] && !active[i] &&
          (selNone || prioOf(allPrio, i) <= prioOf(allPrio, int'(selNum))))
      begin
        selNone = 1'b0;
        selNum = 5'(i);
      end
  end

  // Only enabled interrupts can be offered
  assign sel = !selNone && enable[selNum];

  // The lowest numbered active interrupt ends on exception return.
  always_comb
  begin
    actAny = 1'b0;
    actNum = '0;
    for (int i = N - 1; i >= 0; i--)
      if (active[i])
      begin
        actAny = 1'b1;
        actNum = 5'(i);
      end
  end

  // Request sets pending regardless of enable; set beats clear
  // Pending set and clear by software
  always_comb
  begin
    next_pending = pending;
    if (bus.wr && bus.addr == `NVIRQ_CLR_PEND_OFF)
      next_pending = next_pending & ~bus.wdata;
    if (irqValid && coreAck)
      next_pending[irqNum] = 1'b0;
    next_pending = next_pending | reqEvent;
    if (bus.wr && bus.addr == `NVIRQ_SET_PEND_OFF)
      next_pending = next_pending | bus.wdata;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pending <= '0;
    else
      pending <= next_pending;
  end

  // Active ends only on exception return; disable does not touch it
  // Clear-pending writes never reach the active state
  always_comb
  begin
    next_active = active;
    if (excReturn && actAny)
      next_active[actNum] = 1'b0;
    if (irqValid && coreAck)
      next_active[irqNum] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      active <= '0;
    else
      active <= next_active;
  end

  // Offer to the core, held one cycle behind the selection.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqValid <= 1'b0;
      irqNum <= '0;
      nmiReq <= 1'b0;
    end
    else
    begin
      irqValid <= sel && !(irqValid && coreAck) && enable[selNum]
                  && !(bus.wr && bus.addr == `NVIRQ_CLR_EN_OFF);
      irqNum <= selNum;
      // Non-maskable line bypasses the enable state
      nmiReq <= nmiLevel;
    end
  end

  // One register block decode
  // Priority words come from the flat store so that the read data leave
  // the block straight from this register, one cycle after the strobe.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      regRdata <= '0;
    else if (bus.rd && isPrio(bus.addr))
      regRdata <= allPrio[32*bus.addr[4:2] +: 32];
    else if (bus.rd)
    begin
      unique case (bus.addr)
        `NVIRQ_SET_EN_OFF, `NVIRQ_CLR_EN_OFF: regRdata <= enable;
        `NVIRQ_SET_PEND_OFF, `NVIRQ_CLR_PEND_OFF: regRdata <= pending;
        `NVIRQ_ACTIVE_OFF: regRdata <= active;
        `NVIRQ_SENSE_OFF: regRdata <= pulseMode;
        `NVIRQ_STATUS_OFF: regRdata <= {25'h0, sel, selNone ? 1'b0 : 1'b1,
                                        selNum};
        default: regRdata <= '0;
      endcase
    end
  end

  // Request on a disabled line pends without activation
  a_pend_disabled: assert property (@(posedge core_clk) disable iff (!rst_n)
    |reqEvent |=> ((pending & $past(reqEvent)) == $past(reqEvent))
    && ((active & ~$past(active) & $past(reqEvent & ~enable))
    == 32'h0));
  a_active_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
    !excReturn |=> ((active & $past(active)) == $past(active)));
  // No offer of a disabled interrupt
  a_no_disabled: assert property (@(posedge core_clk) disable iff (!rst_n)
    irqValid |-> enable[irqNum]);
  // Set-enable write takes effect next cycle
  a_set_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus.wr && bus.addr == `NVIRQ_SET_EN_OFF |=> (enable & $past(bus.wdata))
    == $past(bus.wdata));
  a_clr_enable: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus.wr && bus.addr == `NVIRQ_CLR_EN_OFF |=> (enable & $past(bus.wdata))
    == 32'h0);
  a_set_pend: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus.wr && bus.addr == `NVIRQ_SET_PEND_OFF |=> (pending & $past(bus.wdata))
    == $past(bus.wdata));
  a_clrpend_act: assert property (@(posedge core_clk) disable iff (!rst_n)
    bus.wr && bus.addr == `NVIRQ_CLR_PEND_OFF && !excReturn
    |=> active == ($past(active) | ($past(irqValid && coreAck) ?
    (32'h1 << $past(irqNum)) : 32'h0)));
  // Non-maskable request follows the filtered line
  a_nmi_follow: assert property (@(posedge core_clk) disable iff (!rst_n)
    nmiLevel |=> nmiReq);
endmodule
`default_nettype wire

// [inc/nvirq_params.svh]
// Register offsets, field positions and reset values of the interrupt unit.
`ifndef NVIRQ_PARAMS_SVH
`define NVIRQ_PARAMS_SVH
`define NVIRQ_NUM_IRQ      32
`define NVIRQ_ADDR_W       8
`define NVIRQ_SET_EN_OFF   8'h00
`define NVIRQ_CLR_EN_OFF   8'h04
`define NVIRQ_SET_PEND_OFF 8'h08
`define NVIRQ_CLR_PEND_OFF 8'h0c
`define NVIRQ_ACTIVE_OFF   8'h10
`define NVIRQ_SENSE_OFF    8'h14
`define NVIRQ_EOI_OFF      8'h18
`define NVIRQ_STATUS_OFF   8'h1c
`define NVIRQ_PRIO_OFF     8'h20
`define NVIRQ_PRIO_LAST    8'h3c
`define NVIRQ_PRIO_LSB     6
`define NVIRQ_PRIO_MSB     7
`define NVIRQ_RESET_WORD   32'h0000_0000
`define NVIRQ_NO_IRQ       6'h3f
`endif

// [inc/nvirq_pkg.sv]
// Types shared by the interrupt unit files.
package nvirq_pkg;
  typedef logic [31:0] nvirq_word_t;
  typedef logic [7:0]  nvirq_prio_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } nvirq_bus_t;
  typedef struct packed {
    logic       valid;
    logic [4:0] num;
    logic       nmi;
  } nvirq_req_t;
endpackage

// [rtl/nvirq_prio_mem.sv]
// Priority byte store: eight words of four 8-bit fields, registered read.
`include "nvirq_params.svh"
`timescale 1ns/100ps
`default_nettype none
module nvirq_prio_mem
(
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  // Write port
  input  wire logic         wrEn,
  input  wire logic [2:0]   wrIdx,
  input  wire logic [31:0]  wrData,
  // Read port
  input  wire logic [2:0]   rdIdx,
  output logic      [31:0]  rdData,
  // All fields flat
  output logic      [255:0] allPrio
);
  logic [31:0] mem [8];

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < 8; i++)
        mem[i] <= `NVIRQ_RESET_WORD;
    end
    else if (wrEn)
      mem[wrIdx] <= wrData;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdData <= `NVIRQ_RESET_WORD;
    else
      rdData <= mem[rdIdx];
  end

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      allPrio[i*32 +: 32] = mem[i];
  end
endmodule
`default_nettype wire

// [dv/nvirq_core_model.sv]
// Processor core stand-in that takes offered interrupts and returns.
`timescale 1ns/100ps
`default_nettype none
module nvirq_core_model
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Offer from the unit
  input  wire logic       irqValid,
  // Behaviour controls
  input  wire logic [3:0] ackDelay,
  input  wire logic       holdRet,
  // Answers to the unit
  output logic            coreAck,
  output logic            excReturn
);
  logic [3:0] waitCnt;
  logic       inHandler;

  // Only one handler runs at a time, so the return is never skipped.
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      waitCnt   <= 4'h0;
      inHandler <= 1'b0;
      coreAck   <= 1'b0;
      excReturn <= 1'b0;
    end
    else
    begin
      coreAck   <= 1'b0;
      excReturn <= 1'b0;
      if (inHandler && !holdRet && !coreAck)
      begin
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt == ackDelay)
        begin
          excReturn <= 1'b1;
          inHandler <= 1'b0;
          waitCnt   <= 4'h0;
        end
      end
      else if (!inHandler && irqValid)
      begin
        waitCnt <= waitCnt + 4'h1;
        if (waitCnt == ackDelay)
        begin
          coreAck   <= 1'b1;
          inHandler <= 1'b1;
          waitCnt   <= 4'h0;
        end
      end
    end
endmodule
`default_nettype wire

// [dv/nvirq_unit_tb.sv]
// Self-checking bench of the interrupt unit.
`include "nvirq_params.svh"
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, sn) begin logic [31:0] e_, s_; e_ = ex; s_ = sn; \
  tests_run++; if (s_ !== e_) begin n_mismatch++; \
  $display("unexpected %s exp %h seen %h", nm, e_, s_); end end
module nvirq_unit_tb;
  logic core_clk, rst_n, regWr, regRd, nmiLine, coreAck, excReturn;
  logic irqValid, nmiReq, rdSeen, holdRet, bad;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, irqLine, m;
  logic [4:0]  irqNum;
  logic [3:0]  ackDelay;
  logic [31:0] expQ[$];
  logic [4:0]  ackQ[$];
  int n_mismatch, tests_run, cyc, seed;

  nvirq_unit nvirq_unit_i (.core_clk(core_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irqLine(irqLine), .nmiLine(nmiLine),
    .coreAck(coreAck), .excReturn(excReturn), .irqValid(irqValid),
    .irqNum(irqNum), .nmiReq(nmiReq));
  nvirq_core_model nvirq_core_model_i (.core_clk(core_clk), .rst_n(rst_n),
    .irqValid(irqValid), .ackDelay(ackDelay), .holdRet(holdRet),
    .coreAck(coreAck), .excReturn(excReturn));

  // ----------------------------------------------------------------
  // Bus tasks and result watcher
  // ----------------------------------------------------------------
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    expQ.push_back(e);
    @(posedge core_clk);
    regRd <= 1'b0;
  endtask
  task results;
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Read data stand from the cycle after the strobe until the next read.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      results;
    end
    if (rdSeen)
      `CHK("read data", expQ.pop_front(), regRdata)
    if (coreAck && irqValid)
      `CHK("offered number", ackQ.pop_front(), irqNum)
    rdSeen <= regRd;
  end

  initial
  begin
    {rst_n, regWr, regRd, nmiLine, holdRet} = 5'h00;
    {regAddr, regWdata, irqLine} = 72'h0;
    ackDelay = 4'h9;
    seed = 19;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(`NVIRQ_SET_EN_OFF, 32'h0);
    rd(`NVIRQ_SET_PEND_OFF, 32'h0);
    m = $random(seed);
    wr(`NVIRQ_SET_EN_OFF, m);
    rd(`NVIRQ_SET_EN_OFF, m);
    wr(`NVIRQ_CLR_EN_OFF, m);
    rd(`NVIRQ_CLR_EN_OFF, 32'h0);
    m = $random(seed);
    wr(`NVIRQ_SET_PEND_OFF, m);
    rd(`NVIRQ_CLR_PEND_OFF, m);
    wr(`NVIRQ_CLR_PEND_OFF, m);
    rd(`NVIRQ_SET_PEND_OFF, 32'h0);
    for (int k = 0; k < 8; k++)
    begin
      m = $random(seed);
      wr(`NVIRQ_PRIO_OFF + 8'(4 * k), m);
      rd(`NVIRQ_PRIO_OFF + 8'(4 * k), m & 32'hc0c0_c0c0);
    end
    wr(`NVIRQ_EOI_OFF, 32'hffff_ffff);
    rd(`NVIRQ_EOI_OFF, 32'h0);
    // Priorities: irq2 lowest, irq5 next, irq6 and irq9 tie on top.
    wr(8'h20, 32'h0080_0000);
    wr(8'h24, 32'h0000_4000);
    wr(8'h28, 32'h0);
    ackQ = '{5'h06, 5'h09, 5'h05, 5'h02};
    wr(`NVIRQ_SET_PEND_OFF, 32'h0000_0264);
    wr(`NVIRQ_SET_EN_OFF, 32'h0000_0264);
    for (int i = 0; i < 400 && ackQ.size() > 0; i++) @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    rd(`NVIRQ_SET_PEND_OFF, 32'h0);
    // Active interrupt outlives disable and clear-pending.
    holdRet  <= 1'b1;
    ackDelay <= 4'h0;
    ackQ.push_back(5'h04);
    wr(`NVIRQ_SET_EN_OFF, 32'h10);
    wr(`NVIRQ_SET_PEND_OFF, 32'h10);
    for (int i = 0; i < 50 && ackQ.size() > 0; i++) @(posedge core_clk);
    wr(`NVIRQ_CLR_EN_OFF, 32'hffff_ffff);
    wr(`NVIRQ_SET_PEND_OFF, 32'h10);
    wr(`NVIRQ_CLR_PEND_OFF, 32'h10);
    rd(`NVIRQ_ACTIVE_OFF, 32'h10);
    wr(`NVIRQ_SET_PEND_OFF, 32'h10);
    bad = 1'b0;
    repeat (10) @(posedge core_clk) bad |= (irqValid !== 1'b0);
    `CHK("offer while disabled", 1'b0, bad)
    holdRet <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(`NVIRQ_ACTIVE_OFF, 32'h0);
    // A disabled line still pends.
    irqLine <= 32'h8;
    repeat (8) @(posedge core_clk);
    `CHK("offer on pin", 1'b0, irqValid)
    rd(`NVIRQ_SET_PEND_OFF, 32'h18);
    // A level line still high pends again at once after a clear.
    wr(`NVIRQ_CLR_PEND_OFF, 32'h8);
    rd(`NVIRQ_SET_PEND_OFF, 32'h18);
    irqLine <= 32'h0;
    repeat (8) @(posedge core_clk);
    wr(`NVIRQ_CLR_PEND_OFF, 32'hffff_ffff);
    rd(`NVIRQ_SET_PEND_OFF, 32'h0);
    wr(`NVIRQ_SENSE_OFF, 32'h80);
    rd(`NVIRQ_SENSE_OFF, 32'h80);
    irqLine <= 32'h80;
    repeat (8) @(posedge core_clk);
    rd(`NVIRQ_SET_PEND_OFF, 32'h80);
    // A pulse line held high does not pend again once cleared.
    wr(`NVIRQ_CLR_PEND_OFF, 32'h80);
    rd(`NVIRQ_SET_PEND_OFF, 32'h0);
    irqLine <= 32'h0;
    nmiLine <= 1'b1;
    repeat (6) @(posedge core_clk);
    `CHK("nmi request", 1'b1, nmiReq)
    nmiLine <= 1'b0;
    repeat (6) @(posedge core_clk);
    `CHK("nmi release", 1'b0, nmiReq)
    results;
  end
endmodule
`default_nettype wire
